// [shared/status_tree_pkg.sv]
// Package for the status register tree: constants, command codes, carriers.
// Assumes one 200 MHz clock and a command decoder that issues one command a cycle.
package status_tree_pkg;

    localparam int WORD_W = 16;
    localparam int NUM_REGS = 5;
    localparam int QUEUE_DEPTH = 8;
    localparam int QPTR_W = 3;

    // Indices of the five registers
    localparam int IDX_OPER = 0;
    localparam int IDX_QUES = 1;
    localparam int IDX_FREQ = 2;
    localparam int IDX_LIMIT = 3;
    localparam int IDX_POWER = 4;

    // Positions of the sub-register summaries inside the questionable condition
    localparam int QUES_POWER_BIT = 3;
    localparam int QUES_FREQ_BIT = 5;
    localparam int QUES_LIMIT_BIT = 9;

    // Reset and preset values
    localparam logic [15:0] PTR_PRESET = 16'hffff;
    localparam logic [15:0] NTR_PRESET = 16'h0000;
    localparam logic [15:0] ENABLE_PRESET = 16'h0000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] NO_ERROR_CODE = 16'h0000;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_PRESET,
        OP_INST_RESET,
        OP_CLEAR_STATUS,
        OP_DEVICE_CLEAR,
        OP_READ_EVENT,
        OP_READ_COND,
        OP_READ_ENABLE,
        OP_READ_PTR,
        OP_READ_NTR,
        OP_WRITE_ENABLE,
        OP_WRITE_PTR,
        OP_WRITE_NTR,
        OP_READ_QUEUE
    } cmd_op_e;

    typedef struct packed {
        cmd_op_e op;
        logic [2:0] sel;
        logic [15:0] data;
    } cmd_s;

    typedef struct packed {
        logic valid;
        logic noError;
        logic [15:0] data;
    } rsp_s;

    typedef struct packed {
        logic [15:0] prevCond;
        logic [15:0] ptr;
        logic [15:0] ntr;
        logic [15:0] latched;
        logic [15:0] enable;
        logic summary;
    } slice_state_s;

    typedef struct packed {
        logic [NUM_REGS-1:0][15:0] condMeta;
        logic [NUM_REGS-1:0][15:0] condSync;
        logic [QUEUE_DEPTH-1:0][15:0] queue;
        logic [QPTR_W-1:0] readPtr;
        logic [QPTR_W-1:0] writePtr;
        logic [QPTR_W:0] count;
        rsp_s rsp;
        logic operSummary;
        logic quesSummary;
    } tree_state_s;

endpackage

// [core/status_reg_slice.sv]
// One status register: condition edge filters, event latch, enable mask, summary.
// Assumes condition bits are already synchronous to clock.
`timescale 1ns/100ps
`default_nettype none
module status_reg_slice (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clockEnable,
    // Condition bits
    input wire logic [15:0] cond,
    // Control strobes
    input wire logic writePtr,
    input wire logic writeNtr,
    input wire logic writeEnable,
    input wire logic [15:0] writeData,
    input wire logic readClear,
    input wire logic presetFilters,
    input wire logic clearEvents,
    // Register contents
    output logic [15:0] eventBits,
    output logic [15:0] ptrBits,
    output logic [15:0] ntrBits,
    output logic [15:0] enableBits,
    output logic summary
);
    import status_tree_pkg::*;

    slice_state_s s;
    slice_state_s next_s;
    logic [15:0] rise;
    logic [15:0] fall;

    assign rise = cond & ~s.prevCond;
    assign fall = ~cond & s.prevCond;

    always_comb begin
        next_s = s;
        next_s.prevCond = cond;
        if (presetFilters) begin
            next_s.ptr = PTR_PRESET;
            next_s.ntr = NTR_PRESET;
            next_s.enable = ENABLE_PRESET;
        end
        if (writePtr) begin
            next_s.ptr = writeData;
        end
        if (writeNtr) begin
            next_s.ntr = writeData;
        end
        if (writeEnable) begin
            next_s.enable = writeData;
        end
        // New edges are ORed in after the clear so a coincident event survives
        next_s.latched = (readClear || clearEvents) ? WORD_ZERO : s.latched;
        next_s.latched = next_s.latched | (rise & s.ptr);
        next_s.latched = next_s.latched | (fall & s.ntr);
        next_s.summary = |(next_s.latched & next_s.enable);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= '{prevCond: WORD_ZERO, ptr: PTR_PRESET, ntr: NTR_PRESET,
                   latched: WORD_ZERO, enable: ENABLE_PRESET, summary: 1'b0};
        end else if (clockEnable) begin
            s <= next_s;
        end
    end

    assign eventBits = s.latched;
    assign ptrBits = s.ptr;
    assign ntrBits = s.ntr;
    assign enableBits = s.enable;
    assign summary = s.summary;

    ////////////////////////////////////////////////////////////////////////////////
    a_ptr_preset: assert property (@(posedge clock) disable iff (!rst_n)
        clockEnable && presetFilters && !writePtr |=> s.ptr == PTR_PRESET)
        else $error("Positive filter not preset to all ones");
    a_ntr_preset: assert property (@(posedge clock) disable iff (!rst_n)
        clockEnable && presetFilters && !writeNtr |=> s.ntr == NTR_PRESET)
        else $error("Negative filter not cleared by preset");
    a_enable_preset: assert property (@(posedge clock) disable iff (!rst_n)
        clockEnable && presetFilters && !writeEnable |=> s.enable == ENABLE_PRESET)
        else $error("Enable mask not cleared by preset");
    a_rise_sets_event: assert property (@(posedge clock) disable iff (!rst_n)
        clockEnable && (rise & s.ptr) != WORD_ZERO |=> (s.latched & $past(rise & s.ptr)) == $past(rise & s.ptr))
        else $error("Rising condition with filter set did not latch event");
    a_fall_sets_event: assert property (@(posedge clock) disable iff (!rst_n)
        clockEnable && (fall & s.ntr) != WORD_ZERO |=> (s.latched & $past(fall & s.ntr)) == $past(fall & s.ntr))
        else $error("Falling condition with filter set did not latch event");
    a_read_clears_event: assert property (@(posedge clock) disable iff (!rst_n)
        clockEnable && readClear && (rise & s.ptr) == WORD_ZERO && (fall & s.ntr) == WORD_ZERO
        |=> s.latched == WORD_ZERO)
        else $error("Event read did not clear the event section");
    a_summary_or: assert property (@(posedge clock) disable iff (!rst_n)
        summary == |(s.latched & s.enable))
        else $error("Summary differs from OR of enabled events");
    a_summary_rise: assert property (@(posedge clock) disable iff (!rst_n)
        clockEnable && !readClear && !clearEvents && !presetFilters && !writeEnable
        && ((rise & s.ptr & s.enable) != WORD_ZERO) |=> summary)
        else $error("Enabled event did not raise the summary");
    c_summary_rise: cover property (@(posedge clock) disable iff (!rst_n) $rose(summary));
    c_fall_event: cover property (@(posedge clock) disable iff (!rst_n) clockEnable && (fall & s.ntr) != WORD_ZERO);

endmodule // status_reg_slice
`default_nettype wire

// [core/status_register_tree.sv]
// Status register tree: operation and questionable registers with three
// questionable sub-registers, status preset, clears and a FIFO error queue.
// Assumes a command decoder on the same clock; condition inputs are asynchronous pins.
// What this block does
// - The instrument reset command leaves every status register part unchanged.
// - The operation register condition bits carry the calibration state.
// - The questionable register and its frequency, limit and power sub-registers report oscillator, overload and limit status.
// - Status preset loads every positive-transition filter with all sixteen bits set.
// - Status preset clears every negative-transition filter to zero.
// - Status preset clears the enable masks so no event reaches a summary bit.
// - A 1-to-0 condition change with its negative filter bit set sets the event bit.
// - A 0-to-1 condition change with its positive filter bit set sets the event bit.
// - Filters and enable masks accept any 16-bit value written by the controller.
// - An enabled event bit becoming true raises the summary bit to the next level.
// - Reading an event section returns it and clears it in the same operation.
// - Reading a condition section returns current conditions and leaves events untouched.
// - Reading the error queue returns the oldest entry and removes it.
// - Reading an empty error queue returns error number zero with a no-error indication.
// - Device-specific errors are stored as positive numbers, protocol errors as negative.
// - Clear-status empties events and queue; device clear also clears enables and reloads filters.
`timescale 1ns/100ps
`default_nettype none
module status_register_tree (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clockEnable,
    // Condition pins
    input wire logic [15:0] calibrationCond,
    input wire logic [15:0] questionableCond,
    input wire logic [15:0] frequencyCond,
    input wire logic [15:0] limitCond,
    input wire logic [15:0] powerCond,
    // Command port
    input wire logic cmdValid,
    input wire status_tree_pkg::cmd_s cmd,
    // Error reports
    input wire logic errPush,
    input wire logic errDeviceSpecific,
    input wire logic [14:0] errNumber,
    // Answers and summaries
    output var status_tree_pkg::rsp_s rsp,
    output logic operSummary,
    output logic quesSummary
);
    import status_tree_pkg::*;

    tree_state_s s;
    tree_state_s next_s;
    logic [NUM_REGS-1:0][15:0] sliceCond;
    logic [NUM_REGS-1:0][15:0] eventAll;
    logic [NUM_REGS-1:0][15:0] ptrAll;
    logic [NUM_REGS-1:0][15:0] ntrAll;
    logic [NUM_REGS-1:0][15:0] enableAll;
    logic [NUM_REGS-1:0] summaryAll;
    logic opPreset;
    logic opCls;
    logic opDcl;
    logic popDo;
    logic pushDo;
    logic [15:0] errCode;

    function automatic logic hits(input logic valid, input cmd_s c, input cmd_op_e op, input int idx);
        hits = valid && c.op == op && c.sel == idx[2:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Condition words; sub-register summaries are same-clock and skip the synchroniser
    always_comb begin
        sliceCond = s.condSync;
        sliceCond[IDX_QUES][QUES_FREQ_BIT] = summaryAll[IDX_FREQ];
        sliceCond[IDX_QUES][QUES_LIMIT_BIT] = summaryAll[IDX_LIMIT];
        sliceCond[IDX_QUES][QUES_POWER_BIT] = summaryAll[IDX_POWER];
    end

    // Instrument reset decodes to nothing here, so every status part holds
    assign opPreset = cmdValid && cmd.op == OP_PRESET;
    assign opCls = cmdValid && cmd.op == OP_CLEAR_STATUS;
    assign opDcl = cmdValid && cmd.op == OP_DEVICE_CLEAR;

    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : regs
            status_reg_slice slice (
                .clock(clock),
                .rst_n(rst_n),
                .clockEnable(clockEnable),
                .cond(sliceCond[g]),
                .writePtr(hits(cmdValid, cmd, OP_WRITE_PTR, g)),
                .writeNtr(hits(cmdValid, cmd, OP_WRITE_NTR, g)),
                .writeEnable(hits(cmdValid, cmd, OP_WRITE_ENABLE, g)),
                .writeData(cmd.data),
                .readClear(hits(cmdValid, cmd, OP_READ_EVENT, g)),
                .presetFilters(opPreset || opDcl),
                .clearEvents(opCls || opDcl),
                .eventBits(eventAll[g]),
                .ptrBits(ptrAll[g]),
                .ntrBits(ntrAll[g]),
                .enableBits(enableAll[g]),
                .summary(summaryAll[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    assign errCode = errDeviceSpecific ? {1'b0, errNumber} : 16'(-{1'b0, errNumber});
    assign popDo = cmdValid && cmd.op == OP_READ_QUEUE && s.count != '0;
    // A full queue drops the newest report; older causes matter more
    assign pushDo = errPush && ((opCls || opDcl) || popDo || s.count != (QPTR_W+1)'(QUEUE_DEPTH));

    always_comb begin
        next_s = s;
        next_s.condMeta = {powerCond, limitCond, frequencyCond, questionableCond, calibrationCond};
        next_s.condSync = s.condMeta;
        next_s.rsp = '{valid: 1'b0, noError: 1'b0, data: WORD_ZERO};
        next_s.operSummary = summaryAll[IDX_OPER];
        next_s.quesSummary = summaryAll[IDX_QUES];
        if (cmdValid && cmd.sel < 3'(NUM_REGS)) begin
            case (cmd.op)
                OP_READ_EVENT: next_s.rsp = '{valid: 1'b1, noError: 1'b0, data: eventAll[cmd.sel]};
                OP_READ_COND: next_s.rsp = '{valid: 1'b1, noError: 1'b0, data: sliceCond[cmd.sel]};
                OP_READ_ENABLE: next_s.rsp = '{valid: 1'b1, noError: 1'b0, data: enableAll[cmd.sel]};
                OP_READ_PTR: next_s.rsp = '{valid: 1'b1, noError: 1'b0, data: ptrAll[cmd.sel]};
                OP_READ_NTR: next_s.rsp = '{valid: 1'b1, noError: 1'b0, data: ntrAll[cmd.sel]};
                default: next_s.rsp.valid = 1'b0;
            endcase
        end
        if (cmdValid && cmd.op == OP_READ_QUEUE) begin
            if (popDo) begin
                next_s.rsp = '{valid: 1'b1, noError: 1'b0, data: s.queue[s.readPtr]};
                next_s.readPtr = s.readPtr + 1'b1;
                next_s.count = s.count - 1'b1;
            end else begin
                next_s.rsp = '{valid: 1'b1, noError: 1'b1, data: NO_ERROR_CODE};
            end
        end
        if (opCls || opDcl) begin
            next_s.readPtr = '0;
            next_s.writePtr = '0;
            next_s.count = '0;
        end
        // Push after the clear so a report in the clearing cycle is kept
        if (pushDo) begin
            next_s.queue[next_s.writePtr] = errCode;
            next_s.writePtr = next_s.writePtr + 1'b1;
            next_s.count = next_s.count + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= '0;
        end else if (clockEnable) begin
            s <= next_s;
        end
    end

    assign rsp = s.rsp;
    assign operSummary = s.operSummary;
    assign quesSummary = s.quesSummary;

    ////////////////////////////////////////////////////////////////////////////////
    a_inst_reset_hold: assert property (@(posedge clock) disable iff (!rst_n)
        clockEnable && cmdValid && cmd.op == OP_INST_RESET |=> ptrAll == $past(ptrAll) && ntrAll == $past(ntrAll)
        && enableAll == $past(enableAll))
        else $error("Instrument reset altered a status register part");
    a_queue_empty_read: assert property (@(posedge clock) disable iff (!rst_n)
        clockEnable && cmdValid && cmd.op == OP_READ_QUEUE && s.count == '0
        |=> rsp.valid && rsp.noError && rsp.data == NO_ERROR_CODE)
        else $error("Empty queue read did not answer no error");
    a_queue_pop: assert property (@(posedge clock) disable iff (!rst_n)
        clockEnable && popDo && !errPush |=> rsp.valid && !rsp.noError
        && rsp.data == $past(s.queue[s.readPtr]) && s.count == $past(s.count) - 1'b1)
        else $error("Queue read did not return and remove oldest entry");
    a_cond_read_keeps: assert property (@(posedge clock) disable iff (!rst_n)
        clockEnable && cmdValid && cmd.op == OP_READ_COND && cmd.sel == 3'(IDX_OPER)
        |=> rsp.valid && rsp.data == $past(sliceCond[IDX_OPER]) && (eventAll[IDX_OPER] & $past(eventAll[IDX_OPER]))
        == $past(eventAll[IDX_OPER]))
        else $error("Condition read disturbed the event section");
    a_cls_empties_queue: assert property (@(posedge clock) disable iff (!rst_n)
        clockEnable && opCls && !errPush |=> s.count == '0)
        else $error("Clear status did not empty the error queue");
    c_preset: cover property (@(posedge clock) disable iff (!rst_n) clockEnable && opPreset);
    c_queue_read: cover property (@(posedge clock) disable iff (!rst_n) rsp.valid && !rsp.noError);
    c_ques_summary: cover property (@(posedge clock) disable iff (!rst_n) $rose(quesSummary));

endmodule // status_register_tree
`default_nettype wire

// [dv/host_model.sv]
// Remote controller model: issues one status command at a time, reads answer.
// Assumes the tree registers its answer on the taking edge, ready just after it.
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // Clock
    input wire logic clock,
    // Command side
    output logic cmdValid,
    output var status_tree_pkg::cmd_s cmd,
    // Answers
    input wire status_tree_pkg::rsp_s rsp
);
    import status_tree_pkg::*;

    initial begin
        cmdValid = 1'b0;
        cmd = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Held through the taking edge; data scrambled after so no stale word lingers
    task automatic issue(input cmd_op_e op, input logic [2:0] sel, input logic [15:0] data,
                         output logic [15:0] rdata, output logic noErr);
        @(posedge clock);
        #1;
        cmdValid = 1'b1;
        cmd = '{op: op, sel: sel, data: data};
        @(posedge clock);
        #1;
        rdata = 16'hxxxx;
        noErr = 1'bx;
        if (rsp.valid === 1'b1) begin
            rdata = rsp.data;
            noErr = rsp.noError;
        end
        cmdValid = 1'b0;
        cmd.data = ~data;
    endtask
endmodule // host_model
`default_nettype wire

// [dv/tb_status_register_tree.sv]
// Self-checking bench for the status register tree, random with corner cases.
// Assumes the host model drives commands; conditions and errors come from here.
`timescale 1ns/100ps
`default_nettype none
module tb_status_register_tree;
    import status_tree_pkg::*;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic clockEnable = 1'b1;
    logic [15:0] condPins [NUM_REGS] = '{default: 16'h0000};
    logic errPush = 1'b0;
    logic errDeviceSpecific = 1'b0;
    logic [14:0] errNumber = 15'h0000;
    logic cmdValid;
    cmd_s cmd;
    rsp_s rsp;
    logic operSummary;
    logic quesSummary;
    int numErrors = 0;
    int checksDone = 0;
    int seed = 32'h3d31fcc8;
    logic [15:0] got, a, b, e;
    logic gotNe;
    logic [15:0] q [$];

    always #2.5 clock = ~clock;

    host_model u_host_model (.clock(clock), .cmdValid(cmdValid), .cmd(cmd), .rsp(rsp));

    status_register_tree u_status_register_tree (
        .clock(clock), .rst_n(rst_n), .clockEnable(clockEnable),
        .calibrationCond(condPins[IDX_OPER]), .questionableCond(condPins[IDX_QUES]),
        .frequencyCond(condPins[IDX_FREQ]), .limitCond(condPins[IDX_LIMIT]),
        .powerCond(condPins[IDX_POWER]), .cmdValid(cmdValid), .cmd(cmd),
        .errPush(errPush), .errDeviceSpecific(errDeviceSpecific), .errNumber(errNumber),
        .rsp(rsp), .operSummary(operSummary), .quesSummary(quesSummary)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Summary positions read back as zero while sub-register masks are clear
    function automatic logic [15:0] vis(input int s, input logic [15:0] v);
        return (s == IDX_QUES) ? v & ~((16'h1 << QUES_POWER_BIT) | (16'h1 << QUES_FREQ_BIT)
                                       | (16'h1 << QUES_LIMIT_BIT)) : v;
    endfunction

    function automatic logic [15:0] errCode(input logic dev, input logic [14:0] n);
        return dev ? {1'b0, n} : 16'h0000 - {1'b0, n};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp) begin
            numErrors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic req(input cmd_op_e op, input int sel, input logic [15:0] d);
        u_host_model.issue(op, 3'(sel), d, got, gotNe);
    endtask

    task automatic chk3(input int s, input logic [15:0] p, input logic [15:0] n, input logic [15:0] en);
        req(OP_READ_PTR, s, 16'h0000);
        check(got, p);
        req(OP_READ_NTR, s, 16'h0000);
        check(got, n);
        req(OP_READ_ENABLE, s, 16'h0000);
        check(got, en);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic push(input logic dev, input logic [14:0] n);
        @(posedge clock);
        #1;
        errPush = 1'b1;
        errDeviceSpecific = dev;
        errNumber = n;
        @(posedge clock);
        #1;
        errPush = 1'b0;
        errNumber = ~n;
    endtask

    task automatic endOfTest();
        $display("errors %0d, checks %0d", numErrors, checksDone);
        if (numErrors == 0 && checksDone > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        numErrors++;
        endOfTest();
    end

    initial begin
        repeat (6) @(posedge clock);
        #1;
        rst_n = 1'b1;
        // Masks and filters: reset values, full-range writes, untouched by instrument reset
        for (int s = 0; s < NUM_REGS; s++) begin
            chk3(s, PTR_PRESET, NTR_PRESET, ENABLE_PRESET);
            for (int k = 0; k < 3; k++) begin
                a = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : 16'($random(seed));
                req(OP_WRITE_PTR, s, a);
                req(OP_WRITE_NTR, s, ~a);
                req(OP_WRITE_ENABLE, s, a ^ 16'h5a5a);
                req(OP_INST_RESET, s, 16'h0000);
                chk3(s, a, ~a, a ^ 16'h5a5a);
            end
        end
        req(OP_PRESET, 0, 16'h0000);
        for (int s = 0; s < NUM_REGS; s++) chk3(s, PTR_PRESET, NTR_PRESET, ENABLE_PRESET);
        // Edge filters, condition reads and read-clear on every register
        for (int s = 0; s < NUM_REGS; s++) begin
            req(OP_PRESET, 0, 16'h0000);
            a = 16'($random(seed));
            b = 16'($random(seed));
            condPins[s] = a;
            idle(6);
            req(OP_READ_COND, s, 16'h0000);
            check(got, vis(s, a));
            req(OP_READ_EVENT, s, 16'h0000);
            check(got, vis(s, a));
            req(OP_READ_EVENT, s, 16'h0000);
            check(got, 16'h0000);
            req(OP_WRITE_PTR, s, 16'h0000);
            req(OP_WRITE_NTR, s, 16'hffff);
            condPins[s] = a & b;
            idle(6);
            req(OP_READ_EVENT, s, 16'h0000);
            check(got, vis(s, a & ~b));
            condPins[s] = 16'h0000;
            idle(6);
        end
        // Summary bit: enabled and fully masked cases
        for (int k = 0; k < 2; k++) begin
            req(OP_PRESET, 0, 16'h0000);
            req(OP_READ_EVENT, IDX_OPER, 16'h0000);
            a = 16'($random(seed)) | 16'h0001;
            e = (k == 0) ? a : ~a;
            req(OP_WRITE_ENABLE, IDX_OPER, e);
            condPins[IDX_OPER] = a;
            idle(6);
            check({15'h0000, operSummary}, {15'h0000, |(a & e)});
            req(OP_READ_EVENT, IDX_OPER, 16'h0000);
            idle(3);
            check({15'h0000, operSummary}, 16'h0000);
            condPins[IDX_OPER] = 16'h0000;
            idle(6);
        end
        // Frequency sub-register summary climbs into the questionable summary
        req(OP_PRESET, 0, 16'h0000);
        // Stale fall events from the edge tests would raise the summary too early
        req(OP_READ_EVENT, IDX_FREQ, 16'h0000);
        req(OP_WRITE_ENABLE, IDX_FREQ, 16'h0001);
        req(OP_WRITE_ENABLE, IDX_QUES, 16'h1 << QUES_FREQ_BIT);
        req(OP_READ_EVENT, IDX_QUES, 16'h0000);
        condPins[IDX_FREQ] = 16'h0001;
        idle(10);
        check({15'h0000, quesSummary}, 16'h0001);
        req(OP_READ_EVENT, IDX_QUES, 16'h0000);
        check(got, 16'h1 << QUES_FREQ_BIT);
        condPins[IDX_FREQ] = 16'h0000;
        // Error queue: oldest first, signs, overflow drop, empty answer
        for (int i = 0; i < 10; i++) begin
            a = 16'($random(seed));
            push(a[15], a[14:0]);
            if (q.size() < QUEUE_DEPTH) q.push_back(errCode(a[15], a[14:0]));
        end
        for (int i = 0; i < QUEUE_DEPTH; i++) begin
            req(OP_READ_QUEUE, 0, 16'h0000);
            check(got, q.pop_front());
            check({15'h0000, gotNe}, 16'h0000);
        end
        req(OP_READ_QUEUE, 0, 16'h0000);
        check(got, NO_ERROR_CODE);
        check({15'h0000, gotNe}, 16'h0001);
        // Clear status empties events and queue; device clear restores masks
        req(OP_PRESET, 0, 16'h0000);
        push(1'b1, 15'h0005);
        condPins[IDX_OPER] = 16'h00f0;
        idle(6);
        req(OP_CLEAR_STATUS, 0, 16'h0000);
        req(OP_READ_QUEUE, 0, 16'h0000);
        check({gotNe, got[14:0]}, 16'h8000);
        req(OP_READ_EVENT, IDX_OPER, 16'h0000);
        check(got, 16'h0000);
        req(OP_WRITE_PTR, IDX_OPER, 16'h0000);
        req(OP_WRITE_NTR, IDX_LIMIT, 16'hffff);
        req(OP_WRITE_ENABLE, IDX_LIMIT, 16'hffff);
        req(OP_DEVICE_CLEAR, 0, 16'h0000);
        chk3(IDX_OPER, PTR_PRESET, NTR_PRESET, ENABLE_PRESET);
        chk3(IDX_LIMIT, PTR_PRESET, NTR_PRESET, ENABLE_PRESET);
        // Clock enable low loses a command; a mid-run reset restores filters
        req(OP_WRITE_PTR, IDX_OPER, 16'h1234);
        clockEnable = 1'b0;
        req(OP_WRITE_PTR, IDX_OPER, 16'h0000);
        clockEnable = 1'b1;
        chk3(IDX_OPER, 16'h1234, NTR_PRESET, ENABLE_PRESET);
        @(posedge clock);
        #1;
        rst_n = 1'b0;
        idle(3);
        rst_n = 1'b1;
        chk3(IDX_OPER, PTR_PRESET, NTR_PRESET, ENABLE_PRESET);
        idle(4);
        endOfTest();
    end
endmodule // tb_status_register_tree
`default_nettype wire
